// ===== hdl/rim_regbank.v
// Rail 2/3 event mask register and load current measurement registers
`timescale 1ns/1ps
`include "rim_regs.vh"
// How it works
// - Bit 6 set blocks rail 3 goodpower interrupt
// - Bit 4 set blocks rail 3 overcurrent interrupt
// - Bit 2 set blocks rail 2 goodpower interrupt
// - Bit 0 set blocks rail 2 overcurrent interrupt
// - Raw status tracks rail regardless of mask
// - Event masks reset to one, reserved zero
// - Select bits 1:0 choose rail, reset zero
// - Every select write starts a measurement
// - High result holds bits 9:8, rest zero
// - Low result holds bits 7:0, read only
// - Result is 20 mA per LSB, 20 A max
// - Completion raises ready event unless masked
module rim_regbank (
    input  wire        clk,                   // System clock, 125 MHz
    input  wire        rst_b,                 // Async reset, active low
    input  wire        wr_en,                 // Register write strobe, one cycle
    input  wire        rd_en,                 // Register read strobe, one cycle
    input  wire [7:0]  addr,                  // Register offset
    input  wire [7:0]  wdata,                 // Write data
    output reg  [7:0]  rdata,                 // Read data, valid cycle after rd_en
    input  wire        rail2_overcurrent_in,  // Rail 2 current limit, async
    input  wire        rail2_goodpower_in,    // Rail 2 below power-good, async
    input  wire        rail3_overcurrent_in,  // Rail 3 current limit, async
    input  wire        rail3_goodpower_in,    // Rail 3 below power-good, async
    output reg  [3:0]  rail_raw,              // Raw status {r3pg,r3oc,r2pg,r2oc}
    output reg         rail2_overcurrent_event, // Unmasked rising-edge pulse
    output reg         rail2_goodpower_event, // Unmasked rising-edge pulse
    output reg         rail3_overcurrent_event, // Unmasked rising-edge pulse
    output reg         rail3_goodpower_event, // Unmasked rising-edge pulse
    input  wire        ready_irq_block,       // Ready interrupt mask, from top mask reg
    output reg         meas_start,            // Measurement start pulse
    output reg  [1:0]  meas_rail,             // Rail being measured
    input  wire        meas_done,             // Analog side done pulse
    input  wire [9:0]  meas_value,            // Analog side result, valid with done
    output reg         meas_ready_event       // Ready interrupt pulse
);
    reg  [7:0] mask_ff;
    reg  [1:0] sel_ff;
    reg  [9:0] result_ff;
    reg  [3:0] raw_prev_ff;
    wire [3:0] raw_now;
    wire [3:0] raw_chg;

    rim_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({rail3_goodpower_in, rail3_overcurrent_in,
                 rail2_goodpower_in, rail2_overcurrent_in}),
        .q     (raw_now)
    );

    assign raw_chg = raw_now & ~raw_prev_ff;

    // Clamp to 20 A full scale
    function [9:0] clamp_res;
        input [9:0] v;
        begin
            clamp_res = (v > `RIM_RES_MAX) ? `RIM_RES_MAX : v;
        end
    endfunction

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_ff                 <= `RIM_MASK23_RST;
            sel_ff                  <= 2'h0;
            result_ff               <= 10'h000;
            raw_prev_ff             <= 4'h0;
            rail_raw                <= 4'h0;
            rail2_overcurrent_event <= 1'b0;
            rail2_goodpower_event   <= 1'b0;
            rail3_overcurrent_event <= 1'b0;
            rail3_goodpower_event   <= 1'b0;
            meas_start              <= 1'b0;
            meas_rail               <= 2'h0;
            meas_ready_event        <= 1'b0;
            rdata                   <= 8'h00;
        end
        else
        begin
            raw_prev_ff <= raw_now;
            // Raw status ignores the mask entirely
            rail_raw    <= raw_now;
            rail2_overcurrent_event <= raw_chg[0] & ~mask_ff[`RIM_BIT_R2_OC];
            rail2_goodpower_event   <= raw_chg[1] & ~mask_ff[`RIM_BIT_R2_PG];
            rail3_overcurrent_event <= raw_chg[2] & ~mask_ff[`RIM_BIT_R3_OC];
            rail3_goodpower_event   <= raw_chg[3] & ~mask_ff[`RIM_BIT_R3_PG];
            meas_start <= 1'b0;
            if (wr_en && addr == `RIM_OFF_MASK23)
                mask_ff <= wdata & `RIM_MASK23_WMASK;
            if (wr_en && addr == `RIM_OFF_SEL)
            begin
                sel_ff     <= wdata[1:0];
                meas_rail  <= wdata[1:0];
                meas_start <= 1'b1;
            end
            // Result only moves on completion so both halves stay coherent
            if (meas_done)
                result_ff <= clamp_res(meas_value);
            meas_ready_event <= meas_done & ~ready_irq_block;
            if (rd_en)
            begin
                case (addr)
                    `RIM_OFF_MASK23: rdata <= mask_ff;
                    `RIM_OFF_SEL:    rdata <= {6'h00, sel_ff};
                    `RIM_OFF_RES_HI: rdata <= {6'h00, result_ff[9:8]};
                    `RIM_OFF_RES_LO: rdata <= result_ff[7:0];
                    default:         rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // rim_regbank

// ===== hdl/rim_regs.vh
// Register offsets, field positions, reset values and result scaling for the rail mask and load meter
`ifndef RIM_REGS_VH
`define RIM_REGS_VH
`define RIM_ADDR_W          8
`define RIM_OFF_MASK23      8'h20
`define RIM_OFF_SEL         8'h21
`define RIM_OFF_RES_HI      8'h22
`define RIM_OFF_RES_LO      8'h23
`define RIM_BIT_R2_OC       0
`define RIM_BIT_R2_PG       2
`define RIM_BIT_R3_OC       4
`define RIM_BIT_R3_PG       6
`define RIM_MASK23_RST      8'h55
`define RIM_MASK23_WMASK    8'hDD
`define RIM_SEL_RST         8'h00
`define RIM_RES_W           10
`define RIM_LSB_MA          20
`define RIM_FULL_SCALE_MA   20000
`define RIM_RES_MAX         10'h3E8
`define RIM_READY_MASK_RST  1'b0
`endif

// ===== hdl/rim_sync.v
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module rim_sync #(
    parameter W = 4
) (
    input  wire         clk,   // System clock
    input  wire         rst_b, // Async reset, active low
    input  wire [W-1:0] d,     // Asynchronous inputs
    output reg  [W-1:0] q      // Filtered, synchronised level
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            q     <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // Per bit: update only when the last two stages match
            q     <= (s2_ff & s3_ff) | (q & (s2_ff ^ s3_ff));
        end
    end
endmodule // rim_sync

// ===== tb/rim_meas_model.sv
// Measurement circuit stand-in answering the latest start after a set delay
`timescale 1ns/1ps
module rim_meas_model (
    input wire       clk, rst_b, meas_start,
    input wire [9:0] val,
    input wire [7:0] lat,
    output reg       meas_done,
    output reg [9:0] meas_value
);
    integer n;
    always @(posedge clk or negedge rst_b)
        if (!rst_b) begin n = -1; meas_done <= 1'b0; meas_value <= 10'h2AA; end
        else begin
            meas_done <= 1'b0;
            meas_value <= ~meas_value; // Only valid with the done pulse
            if (meas_start) n = lat;
            else if (n == 0) begin meas_done <= 1'b1; meas_value <= val; end
            if (n >= 0) n = n - 1;
        end
endmodule // rim_meas_model

// ===== tb/rim_regbank_properties.sv
// Concurrent checks on the rail mask and load meter register ports
`timescale 1ns/1ps
module rim_props (
    input wire       clk, rst_b, wr_en, rd_en, meas_start, meas_done, ready_irq_block,
    input wire       meas_ready_event, rail2_goodpower_in, rail2_overcurrent_event,
    input wire [7:0] addr, wdata, rdata,
    input wire [3:0] rail_raw,
    input wire [1:0] meas_rail
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_start; wr_en && addr == 8'h21 |=> meas_start; endproperty
    a_start: assert property (p_start) else $error("no start pulse");
    property p_rail; wr_en && addr == 8'h21 |=> meas_rail == $past(wdata[1:0]); endproperty
    a_rail: assert property (p_rail) else $error("wrong rail");
    property p_rdy; meas_done && !ready_irq_block |=> meas_ready_event; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready pulse");
    property p_blk; meas_done && ready_irq_block |=> !meas_ready_event; endproperty
    a_blk: assert property (p_blk) else $error("ready not blocked");
    property p_hi; rd_en && addr == 8'h22 |=> rdata[7:2] == 6'h00; endproperty
    a_hi: assert property (p_hi) else $error("high byte spare bits set");
    property p_rsv; rd_en && addr == 8'h20 |=> !rdata[5] && !rdata[1]; endproperty
    a_rsv: assert property (p_rsv) else $error("mask spare bits set");
    property p_raw; $rose(rail2_goodpower_in) |-> ##[1:8] rail_raw[1]; endproperty
    a_raw: assert property (p_raw) else $error("raw status stuck");
    property p_pls; rail2_overcurrent_event |=> !rail2_overcurrent_event; endproperty
    a_pls: assert property (p_pls) else $error("event too long");
    c_rdy: cover property (meas_ready_event);
    c_ev: cover property (rail2_overcurrent_event);
    c_hi: cover property (rd_en && addr == 8'h22);
endmodule // rim_props
bind rim_regbank rim_props u_rim_props (.clk, .rst_b, .wr_en, .rd_en, .meas_start, .meas_done,
    .ready_irq_block, .meas_ready_event, .rail2_goodpower_in, .rail2_overcurrent_event, .addr,
    .wdata, .rdata, .rail_raw, .meas_rail);

// ===== tb/rim_regbank_tb.sv
// Self-checking bench for the rail mask and load meter registers
`timescale 1ns/1ps
`include "rim_regs.vh"
module rim_regbank_tb;
    reg clk, rst_b, wr_en, rd_en, rdy_blk;
    reg [7:0] addr, wdata, lat;
    reg [3:0] rin;
    reg [9:0] val, ev, ep;
    wire [7:0] rdata; wire [3:0] rail_raw; wire [1:0] meas_rail; wire [9:0] meas_value;
    wire e0, e1, e2, e3, ms, md, mr;
    integer num_errors = 0, comparisons = 0, seed = 65, evc = 0, i, k, x;
    rim_regbank u_rim_regbank (.clk, .rst_b, .wr_en, .rd_en, .addr, .wdata, .rdata,
        .rail2_overcurrent_in(rin[0]), .rail2_goodpower_in(rin[1]),
        .rail3_overcurrent_in(rin[2]), .rail3_goodpower_in(rin[3]), .rail_raw,
        .rail2_overcurrent_event(e0), .rail2_goodpower_event(e1),
        .rail3_overcurrent_event(e2), .rail3_goodpower_event(e3), .ready_irq_block(rdy_blk),
        .meas_start(ms), .meas_rail, .meas_done(md), .meas_value, .meas_ready_event(mr));
    rim_meas_model u_rim_meas_model (.clk, .rst_b, .meas_start(ms), .val, .lat,
        .meas_done(md), .meas_value);
    initial begin clk = 0; forever #4 clk = ~clk; end
    always @(posedge clk) evc <= evc + e0 + e1 + e2 + e3;
    task chk(input [11:0] got, input [11:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin num_errors = num_errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp); end
        end
    endtask
    task cyc(input integer n); begin repeat (n) @(posedge clk); #1; end endtask
    task wr(input [7:0] a, input [7:0] d);
        begin addr = a; wdata = d; wr_en = 1; cyc(1); wr_en = 0; cyc(1); end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin addr = a; rd_en = 1; cyc(1); rd_en = 0; cyc(1); chk(rdata, e); end
    endtask
    task summarize;
        begin
            $display("Counts: %0d compared, %0d wrong", comparisons, num_errors);
            if (num_errors == 0 && comparisons > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    initial begin #40000; num_errors = num_errors + 1; summarize; end
    initial begin
        {rst_b, wr_en, rd_en, rdy_blk, addr, wdata, rin, lat, val, ep} = 0;
        cyc(20); rst_b = 1;
        rd(8'h20, `RIM_MASK23_RST); rd(8'h21, `RIM_SEL_RST);
        rd(8'h22, 0); rd(8'h23, 0);
        for (i = 0; i < 3; i = i + 1) begin
            x = i == 0 ? 0 : (i == 1 ? `RIM_MASK23_RST : $random(seed));
            wr(8'h20, x); rd(8'h20, x & `RIM_MASK23_WMASK);
            k = evc; rin = 4'hF; cyc(10);
            chk(rail_raw, 4'hF);
            chk(evc - k, !x[0] + !x[2] + !x[4] + !x[6]);
            rin = 0; cyc(10);
        end
        $display("Mask tests done");
        for (i = 0; i < 8; i = i + 1) begin
            val = i == 3 ? 10'h3FF : $random(seed); lat = i[0] ? 40 : 2; rdy_blk = i == 7;
            ev = val > `RIM_RES_MAX ? `RIM_RES_MAX : val;
            x = $random(seed); x[1:0] = i[1:0]; wr(8'h21, x[7:0]);
            if (i[0]) rd(8'h23, ep[7:0]);
            k = 0;
            while (mr !== 1'b1 && k < 60) begin cyc(1); k = k + 1; end
            chk(k < 60, !rdy_blk);
            rd(8'h22, ev[9:8]); rd(8'h23, ev[7:0]); ep = ev;
        end
        $display("Measurement tests done");
        summarize;
    end
endmodule // rim_regbank_tb
